// file: core/rpmc_map.vh
`ifndef RPMC_MAP_VH
`define RPMC_MAP_VH
// ********************************************************************
// Register offsets
// ********************************************************************
`define RPMC_ADDR_POWER_CONTROL_REG 8'h87
`define RPMC_ADDR_TIMER2_MODE_REG 8'hC9
`define RPMC_ADDR_STATUS 8'hF8
// ********************************************************************
// Fields and reset values
// ********************************************************************
`define RPMC_POWER_CONTROL_REG_IDL_BIT 0
`define RPMC_POWER_CONTROL_REG_PD_BIT 1
`define RPMC_POWER_CONTROL_REG_RESET 8'h00
`define RPMC_TIMER2_MODE_REG_MASK 8'h03
`define RPMC_TIMER2_MODE_REG_RESET 8'h00
`define RPMC_LOCK_TABLE_BIT 0
`define RPMC_LOCK_VERIFY_BIT 1
`define RPMC_ROM_TOP 16'h0FFF
// ********************************************************************
// Timing
// ********************************************************************
`define RPMC_RESET_OSC_PERIODS 24
`define RPMC_OSC_PER_MACHINE 12
`endif

// file: core/rpmc_reset_filter.v
`timescale 1ns/10ps
// ********************************************************************
// Reset pin qualifier counted in oscillator periods
// ********************************************************************
module rpmc_reset_filter #(
   parameter HOLD = 24
) (
   // Clock and reset
   clk,
   resetn,
   // Pin side
   resetPin,
   // Result
   resetAccept
);
   input wire clk;
   input wire resetn;
   input wire resetPin;
   output reg resetAccept;
   reg [5:0] holdCnt_q;
   // Counting on the raw crystal clock keeps the span exact in oscillator periods.
   always @(posedge clk) begin
      if (!resetn) begin
         holdCnt_q <= 6'h00;
         resetAccept <= 1'b0;
      end else if (!resetPin) begin
         holdCnt_q <= 6'h00;
         resetAccept <= 1'b0;
      end else begin
         if (holdCnt_q != HOLD[5:0]) begin
            holdCnt_q <= holdCnt_q + 6'h01;
         end
         resetAccept <= (holdCnt_q >= HOLD[5:0] - 6'h01);
      end
   end
endmodule // rpmc_reset_filter

// file: core/rpmc_reset_power_ctrl.v
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "rpmc_map.vh"
// ********************************************************************
// Reset and power mode control
// ********************************************************************
module rpmc_reset_power_ctrl #(
   parameter ROM_TOP = 16'h0FFF
) (
   // Clock and reset
   clk,
   resetn,
   // Device pins in
   resetPin,
   externalAccessSelect,
   // Register port
   regAddr,
   regWrData,
   regWrite,
   regRead,
   regRdData,
   // Core hooks
   instrDone,
   enabledIrq,
   programCounter,
   tableReadReq,
   verifyReadReq,
   lockBitField,
   // Clocks and state out
   phaseClk,
   cpuRun,
   periphRun,
   oscRun,
   ramRetain,
   coreReset,
   fetchExternal,
   tableReadAllow,
   verifyReadAllow,
   // Pin overrides
   addrLatchStrobe,
   programStoreStrobe,
   port0Float,
   port2AddrDrive,
   portHoldData
);
   input wire clk;
   input wire resetn;
   input wire resetPin;
   input wire externalAccessSelect;
   input wire [7:0] regAddr;
   input wire [7:0] regWrData;
   input wire regWrite;
   input wire regRead;
   output reg [7:0] regRdData;
   input wire instrDone;
   input wire enabledIrq;
   input wire [15:0] programCounter;
   input wire tableReadReq;
   input wire verifyReadReq;
   input wire [1:0] lockBitField;
   output reg phaseClk;
   output wire cpuRun;
   output wire periphRun;
   output wire oscRun;
   output wire ramRetain;
   output wire coreReset;
   output wire fetchExternal;
   output wire tableReadAllow;
   output wire verifyReadAllow;
   output reg addrLatchStrobe;
   output reg programStoreStrobe;
   output reg port0Float;
   output reg port2AddrDrive;
   output reg portHoldData;

   localparam [2:0] ST_RUN = 3'b001;
   localparam [2:0] ST_IDLE = 3'b010;
   localparam [2:0] ST_PDOWN = 3'b100;
   localparam [7:0] TIMER2_MODE_REG_RST = `RPMC_TIMER2_MODE_REG_RESET;

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg idleReq_q;
   reg pdReq_q;
   reg [1:0] timer2_mode_reg_q;
   reg eaLatched_q;
   reg eaCaught_q;
   wire resetAccept;
   wire sysReset;
   wire eaEff;

   // ********************************************************************
   // Reset pin qualification
   // ********************************************************************
   rpmc_reset_filter #(
      .HOLD(`RPMC_RESET_OSC_PERIODS)
   ) uFilter (
      .clk(clk),
      .resetn(resetn),
      .resetPin(resetPin),
      .resetAccept(resetAccept)
   );

   assign sysReset = !resetn || resetAccept;
   assign coreReset = sysReset;

   // ********************************************************************
   // Divide-by-two clock phase
   // ********************************************************************
   // The toggle makes internal timing independent of the crystal duty cycle.
   always @(posedge clk) begin
      if (!resetn) begin
         phaseClk <= 1'b0;
      end else if (state_q != ST_PDOWN) begin
         phaseClk <= ~phaseClk;
      end
   end

   // ********************************************************************
   // Mode sequencer
   // ********************************************************************
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (instrDone && pdReq_q) begin
               state_d = ST_PDOWN;
            end else if (instrDone && idleReq_q) begin
               state_d = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (enabledIrq) begin
               state_d = ST_RUN;
            end
         end
         ST_PDOWN: begin
            state_d = ST_PDOWN;
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   always @(posedge clk) begin
      if (sysReset) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // ********************************************************************
   // Power control and timer2 mode registers
   // ********************************************************************
   always @(posedge clk) begin
      if (sysReset) begin
         idleReq_q <= 1'b0;
         pdReq_q <= 1'b0;
         timer2_mode_reg_q <= TIMER2_MODE_REG_RST[1:0];
      end else begin
         if (state_q == ST_IDLE && state_d == ST_RUN) begin
            idleReq_q <= 1'b0;
            pdReq_q <= 1'b0;
         end else if (regWrite && regAddr == `RPMC_ADDR_POWER_CONTROL_REG) begin
            idleReq_q <= regWrData[`RPMC_POWER_CONTROL_REG_IDL_BIT];
            pdReq_q <= regWrData[`RPMC_POWER_CONTROL_REG_PD_BIT];
         end
         if (regWrite && regAddr == `RPMC_ADDR_TIMER2_MODE_REG) begin
            timer2_mode_reg_q <= regWrData[1:0];
         end
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         regRdData <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            `RPMC_ADDR_POWER_CONTROL_REG: regRdData <= {6'h00, pdReq_q, idleReq_q};
            `RPMC_ADDR_TIMER2_MODE_REG: regRdData <= {6'h00, timer2_mode_reg_q};
            `RPMC_ADDR_STATUS: regRdData <= {3'h0, eaLatched_q, 1'b0, state_q};
            default: regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end

   // ********************************************************************
   // External access select and lock bits
   // ********************************************************************
   // The select is caught on the first edge after reset releases, never during it.
   always @(posedge clk) begin
      if (sysReset) begin
         eaCaught_q <= 1'b0;
         eaLatched_q <= 1'b0;
      end else if (!eaCaught_q) begin
         eaCaught_q <= 1'b1;
         eaLatched_q <= externalAccessSelect;
      end
   end

   assign eaEff = lockBitField[`RPMC_LOCK_TABLE_BIT] ? eaLatched_q : externalAccessSelect;
   assign fetchExternal = !eaEff || (programCounter > ROM_TOP);
   assign tableReadAllow = !(tableReadReq && fetchExternal
                             && lockBitField[`RPMC_LOCK_TABLE_BIT]);
   assign verifyReadAllow = !(verifyReadReq
                              && lockBitField[`RPMC_LOCK_VERIFY_BIT]);

   // ********************************************************************
   // Clock gating and pin states
   // ********************************************************************
   assign cpuRun = (state_q == ST_RUN) && !sysReset;
   assign periphRun = (state_q != ST_PDOWN);
   assign oscRun = (state_q != ST_PDOWN);
   assign ramRetain = (state_q != ST_RUN);

   always @(posedge clk) begin
      if (!resetn) begin
         addrLatchStrobe <= 1'b1;
         programStoreStrobe <= 1'b1;
         port0Float <= 1'b0;
         port2AddrDrive <= 1'b0;
         portHoldData <= 1'b0;
      end else begin
         case (state_d)
            ST_IDLE: begin
               addrLatchStrobe <= 1'b1;
               programStoreStrobe <= 1'b1;
               port0Float <= !eaEff;
               port2AddrDrive <= !eaEff;
               portHoldData <= 1'b1;
            end
            ST_PDOWN: begin
               addrLatchStrobe <= 1'b0;
               programStoreStrobe <= 1'b0;
               port0Float <= !eaEff;
               port2AddrDrive <= 1'b0;
               portHoldData <= 1'b1;
            end
            default: begin
               addrLatchStrobe <= 1'b1;
               programStoreStrobe <= 1'b1;
               port0Float <= 1'b0;
               port2AddrDrive <= 1'b0;
               portHoldData <= 1'b0;
            end
         endcase
      end
   end
endmodule // rpmc_reset_power_ctrl

// file: verif/rpmc_assertions.sv
`timescale 1ns/10ps
// ****
// Checker
// ****
module rpmc_assertions #(
   parameter ROM_TOP = 16'h0FFF
) (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Inputs
   input wire externalAccessSelect,
   input wire instrDone,
   input wire verifyReadReq,
   input wire enabledIrq,
   input wire [15:0] programCounter,
   input wire tableReadReq,
   input wire [1:0] lockBitField,
   // Outputs
   input wire phaseClk,
   input wire cpuRun,
   input wire periphRun,
   input wire oscRun,
   input wire ramRetain,
   input wire coreReset,
   input wire fetchExternal,
   input wire tableReadAllow,
   input wire verifyReadAllow,
   input wire addrLatchStrobe,
   input wire programStoreStrobe,
   input wire port0Float,
   input wire portHoldData
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_idle_pins: assert property (
      (!cpuRun && periphRun && !coreReset) |-> addrLatchStrobe && programStoreStrobe)
      else $error("idle strobes wrong");
   a_pd_pins: assert property (
      (!oscRun && !coreReset) |-> !addrLatchStrobe && !programStoreStrobe && portHoldData)
      else $error("power-down pins wrong");
   a_pd_port0: assert property (
      (!oscRun && !coreReset && !lockBitField[0]) |-> port0Float == !$past(externalAccessSelect))
      else $error("power-down port0 wrong");
   a_irq_exit: assert property (
      (!cpuRun && periphRun && enabledIrq && !coreReset) |=> cpuRun)
      else $error("idle not left on interrupt");
   a_pd_no_wake: assert property (
      (!oscRun && !coreReset) |=> !oscRun || coreReset)
      else $error("power-down left without reset");
   a_stop_after_instr: assert property (
      ($fell(cpuRun) && !coreReset) |-> $past(instrDone))
      else $error("cpu stopped without instruction end");
   a_reset_wakes: assert property (
      coreReset |=> oscRun && periphRun)
      else $error("reset did not restart");
   a_verify_lock: assert property (
      (verifyReadReq && lockBitField[1]) |-> !verifyReadAllow)
      else $error("verify read not refused");
   a_ram_retain: assert property (
      (!cpuRun && !coreReset) |-> ramRetain)
      else $error("ram not retained while stopped");
   a_table_lock: assert property (
      (tableReadReq && lockBitField[0] && fetchExternal) |-> !tableReadAllow)
      else $error("table read not blocked");
   a_fetch_select: assert property (
      !lockBitField[0] |-> fetchExternal == (!externalAccessSelect || programCounter > ROM_TOP))
      else $error("fetch source wrong");
   a_phase_div: assert property (
      (oscRun && $past(oscRun) && !coreReset && !$past(coreReset)) |->
         phaseClk != $past(phaseClk))
      else $error("phase clock not toggling");
endmodule // rpmc_assertions
bind rpmc_reset_power_ctrl rpmc_assertions #(.ROM_TOP(ROM_TOP)) rpmc_assertions_i (.*);

// file: verif/rpmc_reset_src.sv
`timescale 1ns/10ps
// ****
// External reset circuit
// ****
module rpmc_reset_src #(
   parameter START = 30
) (
   input wire clk,
   input wire go,
   input wire [7:0] len,
   output wire resetPin
);
   // The pin has a pull-down, so it rests low between pulses.
   reg [7:0] cnt_q = START;
   always @(posedge clk) begin
      if (go) begin
         cnt_q <= len;
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
   assign resetPin = (cnt_q != 8'h00);
endmodule // rpmc_reset_src

// file: verif/tb.sv
`timescale 1ns/10ps
`include "rpmc_map.vh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin mismatches++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb;
   reg clk = 0, resetn = 0, externalAccessSelect = 1, regWrite = 0, regRead = 0;
   reg instrDone = 0, enabledIrq = 0, tableReadReq = 0, verifyReadReq = 0, rsGo = 0, rdPend = 0;
   reg [7:0] regAddr = 0, regWrData = 0, rsLen = 0, rnd, ex;
   reg [15:0] programCounter = 0;
   reg [1:0] lockBitField = 0;
   reg [7:0] expQ[$];
   integer mismatches = 0, checked = 0, i;
   wire [7:0] regRdData;
   wire phaseClk, cpuRun, periphRun, oscRun, ramRetain, coreReset, fetchExternal, resetPin;
   wire tableReadAllow, verifyReadAllow, addrLatchStrobe, programStoreStrobe;
   wire port0Float, port2AddrDrive, portHoldData;
   rpmc_reset_power_ctrl rpmc_reset_power_ctrl_i (.*);
   rpmc_reset_src rpmc_reset_src_i (.clk(clk), .go(rsGo), .len(rsLen), .resetPin(resetPin));
   initial forever #5 clk = ~clk;
   // ****
   // Read data monitor
   // ****
   always @(posedge clk) begin
      if (rdPend) begin
         ex = expQ.pop_front();
         `CHK("regRdData", ex, regRdData)
      end
      rdPend <= regRead;
   end
   task print_verdict;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk); regAddr <= a; regWrData <= d; regWrite <= 1;
      @(posedge clk); regWrite <= 0;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      @(posedge clk); regAddr <= a; regRead <= 1; expQ.push_back(e);
      @(posedge clk); regRead <= 0;
   endtask
   task pulse(input [1:0] w);
      @(posedge clk); {enabledIrq, instrDone} <= w;
      @(posedge clk); {enabledIrq, instrDone} <= 2'b00;
   endtask
   task waitRun;
      integer k;
      for (k = 0; k < 100 && (coreReset !== 1'b0 || resetPin !== 1'b0); k++) @(posedge clk);
      if (k == 100) begin
         mismatches++;
         print_verdict;
      end
   endtask
   task pinRst(input [7:0] n);
      @(posedge clk); rsGo <= 1; rsLen <= n;
      @(posedge clk); rsGo <= 0;
      repeat (n + 2) @(posedge clk);
      waitRun;
   endtask
   task hardRst;
      @(posedge clk); resetn <= 0;
      repeat (2) @(posedge clk); resetn <= 1;
      waitRun;
   endtask
   task pins(input [5:0] e);
      @(negedge clk);
      `CHK("pins", e, {addrLatchStrobe, programStoreStrobe, port0Float, port2AddrDrive, cpuRun, oscRun})
   endtask
   initial begin
      rnd = $urandom(32'hEC44);
      repeat (2) @(posedge clk); resetn <= 1;
      waitRun;
      rd(`RPMC_ADDR_TIMER2_MODE_REG, 8'h00);
      rd(`RPMC_ADDR_POWER_CONTROL_REG, 8'h00);
      rd(`RPMC_ADDR_STATUS, 8'h11);
      rnd = $urandom;
      wr(`RPMC_ADDR_TIMER2_MODE_REG, rnd);
      rd(`RPMC_ADDR_TIMER2_MODE_REG, rnd & 8'h03);
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h00);
      $display("registers done");
      for (i = 0; i < 2; i++) begin
         externalAccessSelect <= ~i[0];
         wr(`RPMC_ADDR_POWER_CONTROL_REG, 8'h01);
         rd(`RPMC_ADDR_POWER_CONTROL_REG, 8'h01);
         pulse(2'b01);
         pins({2'b11, i[0], i[0], 2'b01});
         rd(`RPMC_ADDR_STATUS, 8'h12);
         pulse(2'b10);
         rd(`RPMC_ADDR_POWER_CONTROL_REG, 8'h00);
         rd(`RPMC_ADDR_STATUS, 8'h11);
      end
      wr(`RPMC_ADDR_POWER_CONTROL_REG, 8'h01);
      pulse(2'b01);
      pinRst(8'd24);
      rd(`RPMC_ADDR_STATUS, 8'h01);
      $display("idle done");
      wr(`RPMC_ADDR_POWER_CONTROL_REG, 8'h03);
      pulse(2'b01);
      pins(6'b001000);
      pulse(2'b10);
      pins(6'b001000);
      pinRst(8'd24);
      rd(`RPMC_ADDR_POWER_CONTROL_REG, 8'h00);
      rd(`RPMC_ADDR_STATUS, 8'h01);
      wr(`RPMC_ADDR_TIMER2_MODE_REG, 8'h03);
      pinRst(8'd23);
      rd(`RPMC_ADDR_TIMER2_MODE_REG, 8'h03);
      pinRst(8'd24);
      rd(`RPMC_ADDR_TIMER2_MODE_REG, 8'h00);
      $display("power-down done");
      for (i = 0; i < 4; i++) begin
         lockBitField <= i[1:0];
         externalAccessSelect <= 1;
         tableReadReq <= 1;
         verifyReadReq <= 1;
         hardRst;
         externalAccessSelect <= 0;
         programCounter <= $urandom & 16'h0FFF;
         @(negedge clk);
         `CHK("fetchLow", {~i[0], ~i[1]}, {fetchExternal, verifyReadAllow})
         @(posedge clk); programCounter <= 16'h1000 | $urandom;
         @(negedge clk);
         `CHK("fetchHigh", {1'b1, ~i[0]}, {fetchExternal, tableReadAllow})
         rd(`RPMC_ADDR_STATUS, 8'h11);
      end
      $display("security done");
      repeat (3) @(posedge clk);
      print_verdict;
   end
endmodule // tb
